/* File: src/boot_source_select_and_status.sv */
// boot source selection from straps and otp, with boot status pin and regs
//
// Behaviour
// - boot mode comes from four strap pins plus 2-bit otp field, default 0.
// - strap pins are captured at every reset release and pick the source.
// - captured straps are readable in a register; standby exit resamples.
// - straps 0 and 15 select serial download on two uarts or usb.
// - straps 3 and 12 select development boot, never overridden by otp.
// - default field maps 1,2,4,5,6 to app core and 7,8,11 to mcu core.
// - some entries carry two flash configurations for indirect boot.
// - an empty boot flash falls back to serial download boot, or fails if otp forbids it.
// - otp may force any single boot source, or forbid any except development boot.
// - otp force bits make later boots use the programmed flash, except with development straps.
// - during rom boot peripherals run from the internal fast oscillator.
// - usb download runs only with the external fast oscillator present.
// - boot failure drives the status pin low, open drain.
// - without secure boot a failure falls back at once to serial boot, unless otp forbids serial boot.
// - in serial boot the status pin blinks at a few hertz until linked.
// - development boot holds the status pin low.
// - otherwise the status pin stays high impedance until software.
`timescale 1ns/1ps
`default_nettype none
`include "boot_sel_params.svh"

module boot_source_select_and_status
	import boot_sel_pkg::*;
#(
	parameter int unsigned BLINK_HALF_CYC = `BLINK_HALF_CYC
) (
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic [3:0] boot_pins,
	input  wire otp_cfg_s   otp_cfg,
	input  wire logic       standby_exit,
	input  wire flash_rsp_s flash_rsp,
	input  wire logic       conn_port_a,
	input  wire logic       conn_port_b,
	input  wire logic       conn_usb,
	input  wire logic       ext_osc_present,
	input  wire avmm_req_s  bus_req,
	output avmm_rsp_s       bus_rsp,
	output map_entry_s      boot_sel,
	output logic            flash_start,
	output logic            clk_internal,
	output logic            usb_dl_enable,
	output logic            status_pin_out,
	output logic            status_pin_oe,
	output logic            irq
);

	// a counter this wide cannot hold a longer half period
	if (BLINK_HALF_CYC < 1 || BLINK_HALF_CYC >= (1 << `BLINK_CNT_W)) begin
		$error("BLINK_HALF_CYC out of range for the blink counter");
	end

	localparam logic [`BLINK_CNT_W-1:0] BLINK_LAST =
		`BLINK_CNT_W'(BLINK_HALF_CYC - 1);

	typedef struct packed {
		boot_st_e               st;
		logic [3:0]             pins_m;
		logic [3:0]             pins_s;
		logic [3:0]             cap_pins;
		logic [1:0]             cap_alt;
		map_entry_s             sel;
		logic [1:0]             settle;
		logic [`BLINK_CNT_W-1:0] blink_cnt;
		logic                   flash_start;
		logic                   clk_int;
		logic                   usb_en;
		logic                   pin_out;
		logic                   pin_oe;
		logic                   pin_own;
		logic                   pin_low;
		logic [`IRQ_W-1:0]      irq_stat;
		logic [`IRQ_W-1:0]      irq_mask;
		logic                   irq;
		logic                   waitreq;
		logic [31:0]            rdata;
	} state_s;

	state_s            q;
	state_s            d;
	map_entry_s        ent;
	logic [`IRQ_W-1:0] ev;
	logic [`IRQ_W-1:0] w1c;
	logic              acc;
	logic              resample;
	logic              linked;
	logic              ser_ok;

	// builds one entry of the strap map
	function automatic map_entry_s mk(
		input boot_src_e s,
		input logic      m,
		input boot_src_e s2,
		input logic      c2
	);
		map_entry_s e;
		e.src = s;
		e.mcu_primary = m;
		e.dual = (s2 != SRC_NONE);
		e.src2 = s2;
		e.card_two = c2;
		return e;
	endfunction

	// strap and field to boot source; unmapped cells return no source
	function automatic map_entry_s lookup(
		input logic [3:0] p,
		input logic [1:0] a
	);
		map_entry_s e;
		e = mk(SRC_NONE, 1'b0, SRC_NONE, 1'b0);
		if (p == `STRAP_SER_LO || p == `STRAP_SER_HI) begin
			e = mk(SRC_SERIAL, 1'b0, SRC_NONE, 1'b0);
		end else if (p == `STRAP_DEV_LO || p == `STRAP_DEV_HI) begin
			e = mk(SRC_DEV, 1'b0, SRC_NONE, 1'b0);
		end else begin
			case ({a, p})
			// default field: app core, mcu core, dual configurations
			6'h01: e = mk(SRC_SD, 1'b0, SRC_NONE, 1'b0);
			6'h02: e = mk(SRC_EMMC, 1'b0, SRC_NONE, 1'b0);
			6'h04: e = mk(SRC_SNOR, 1'b0, SRC_NONE, 1'b0);
			6'h05: e = mk(SRC_SNAND, 1'b0, SRC_NONE, 1'b0);
			6'h06: e = mk(SRC_SLC, 1'b0, SRC_NONE, 1'b0);
			6'h07: e = mk(SRC_SD, 1'b1, SRC_NONE, 1'b0);
			6'h08: e = mk(SRC_EMMC, 1'b1, SRC_NONE, 1'b0);
			6'h0b: e = mk(SRC_SNOR, 1'b1, SRC_NONE, 1'b0);
			6'h09: e = mk(SRC_SNAND, 1'b1, SRC_SNOR, 1'b0);
			6'h0a: e = mk(SRC_SLC, 1'b1, SRC_SNOR, 1'b0);
			6'h0d: e = mk(SRC_EMMC, 1'b1, SRC_SNOR, 1'b0);
			6'h0e: e = mk(SRC_SD, 1'b1, SRC_SNOR, 1'b0);
			// field 1: app core primary
			6'h11: e = mk(SRC_SD, 1'b0, SRC_NONE, 1'b0);
			6'h12: e = mk(SRC_EMMC, 1'b0, SRC_NONE, 1'b0);
			6'h14: e = mk(SRC_SNOR, 1'b0, SRC_NONE, 1'b0);
			6'h17: e = mk(SRC_HBUS, 1'b0, SRC_NONE, 1'b0);
			6'h18: e = mk(SRC_SNAND, 1'b0, SRC_NONE, 1'b0);
			6'h1b: e = mk(SRC_SLC, 1'b0, SRC_NONE, 1'b0);
			6'h1d: e = mk(SRC_SD, 1'b0, SRC_NONE, 1'b1);
			6'h1e: e = mk(SRC_EMMC, 1'b0, SRC_NONE, 1'b0);
			// field 2: mcu core primary
			6'h21: e = mk(SRC_SD, 1'b1, SRC_NONE, 1'b0);
			6'h22: e = mk(SRC_EMMC, 1'b1, SRC_NONE, 1'b0);
			6'h24: e = mk(SRC_SNOR, 1'b1, SRC_NONE, 1'b0);
			6'h27: e = mk(SRC_HBUS, 1'b1, SRC_NONE, 1'b0);
			6'h28: e = mk(SRC_SNAND, 1'b1, SRC_NONE, 1'b0);
			6'h2b: e = mk(SRC_SLC, 1'b1, SRC_NONE, 1'b0);
			6'h2d: e = mk(SRC_SD, 1'b1, SRC_NONE, 1'b1);
			6'h2e: e = mk(SRC_EMMC, 1'b1, SRC_NONE, 1'b0);
			// field 3: two configurations, mcu starts the app core
			6'h32: e = mk(SRC_EMMC, 1'b1, SRC_SNOR, 1'b0);
			6'h34: e = mk(SRC_SLC, 1'b1, SRC_SNOR, 1'b0);
			6'h35: e = mk(SRC_EMMC, 1'b1, SRC_SNOR, 1'b0);
			6'h36: e = mk(SRC_EMMC, 1'b1, SRC_HBUS, 1'b0);
			6'h38: e = mk(SRC_EMMC, 1'b1, SRC_HBUS, 1'b0);
			6'h39: e = mk(SRC_SD, 1'b1, SRC_SNOR, 1'b1);
			6'h3a: e = mk(SRC_SD, 1'b1, SRC_HBUS, 1'b1);
			6'h3b: e = mk(SRC_SLC, 1'b1, SRC_HBUS, 1'b0);
			6'h3d: e = mk(SRC_SD, 1'b1, SRC_SNOR, 1'b0);
			6'h3e: e = mk(SRC_SD, 1'b1, SRC_HBUS, 1'b0);
			default: e = mk(SRC_NONE, 1'b0, SRC_NONE, 1'b0);
			endcase
		end
		return e;
	endfunction

	// whole next state; pins are assumed static after reset release
	always_comb begin
		d = q;
		ev = '0;
		w1c = '0;
		d.flash_start = 1'b0;
		d.pin_out = 1'b0;

		// two-flop strap synchroniser
		d.pins_m = boot_pins;
		d.pins_s = q.pins_m;

		// otp force wins over the straps except for development boot
		ent = lookup(q.cap_pins, q.cap_alt);
		if (ent.src != SRC_DEV && otp_cfg.force_en) begin
			ent = mk(otp_cfg.force_src, 1'b0, SRC_NONE, 1'b0);
		end
		if (ent.src == SRC_NONE) begin
			ent = mk(SRC_SERIAL, 1'b0, SRC_NONE, 1'b0);
		end
		ser_ok = !otp_cfg.forbid[SRC_SERIAL];

		// bus access completes on the cycle waitrequest is low
		acc = (bus_req.read || bus_req.write) && !q.waitreq;
		resample = standby_exit;
		if (acc && bus_req.write && bus_req.address == `REG_CTRL) begin
			resample = resample || bus_req.writedata[`CTRL_RESAMPLE];
			d.pin_own = bus_req.writedata[`CTRL_PIN_OWN];
			d.pin_low = bus_req.writedata[`CTRL_PIN_LOW];
		end
		if (acc && bus_req.write && bus_req.address == `REG_IRQ_STAT) begin
			w1c = bus_req.writedata[`IRQ_W-1:0];
		end
		if (acc && bus_req.write && bus_req.address == `REG_IRQ_MASK) begin
			d.irq_mask = bus_req.writedata[`IRQ_W-1:0];
		end

		// a usb link counts only with the external oscillator running
		linked = conn_port_a || conn_port_b || (conn_usb && q.usb_en);

		case (q.st)
		ST_SETTLE: begin
			// wait until the synchroniser holds the pin level
			d.pin_oe = 1'b0;
			d.clk_int = 1'b1;
			d.settle = q.settle + 2'h1;
			if (q.settle == `SETTLE_CYC) begin
				d.cap_pins = q.pins_s;
				d.cap_alt = otp_cfg.alt;
				d.st = ST_RESOLVE;
				ev[`IRQ_SAMPLED] = 1'b1;
			end
		end
		ST_RESOLVE: begin
			d.sel = ent;
			case (ent.src)
			SRC_DEV: begin
				d.st = ST_DEV;
			end
			SRC_SERIAL: begin
				d.st = ser_ok ? ST_SERIAL : ST_FAIL;
				d.blink_cnt = '0;
			end
			default: begin
				if (otp_cfg.forbid[ent.src]) begin
					d.st = ST_FAIL;
				end else begin
					d.st = ST_FLASH;
					d.flash_start = 1'b1;
				end
			end
			endcase
			ev[`IRQ_FAIL] = (d.st == ST_FAIL);
			d.pin_oe = (d.st == ST_FAIL || d.st == ST_DEV);
		end
		ST_FLASH: begin
			if (flash_rsp.done) begin
				if (flash_rsp.empty) begin
					d.st = ser_ok ? ST_SERIAL : ST_FAIL;
					d.blink_cnt = '0;
					ev[`IRQ_FAIL] = !ser_ok;
					d.pin_oe = !ser_ok;
				end else if (flash_rsp.error) begin
					d.st = ST_FAIL;
					ev[`IRQ_FAIL] = 1'b1;
					d.pin_oe = 1'b1;
				end else begin
					d.st = ST_BOOTED;
					ev[`IRQ_BOOTED] = 1'b1;
				end
			end
		end
		ST_FAIL: begin
			// secure parts stay here with the pin low until a resample
			if (!otp_cfg.secure && ser_ok) begin
				d.st = ST_SERIAL;
				d.blink_cnt = '0;
				d.pin_oe = 1'b0;
			end
		end
		ST_SERIAL: begin
			// divider enable toggles the open-drain drive
			if (q.blink_cnt == BLINK_LAST) begin
				d.blink_cnt = '0;
				d.pin_oe = !q.pin_oe;
			end else begin
				d.blink_cnt = q.blink_cnt + `BLINK_CNT_W'(1);
			end
			if (linked) begin
				d.st = ST_LINKED;
				d.pin_oe = 1'b0;
				ev[`IRQ_LINK] = 1'b1;
			end
		end
		ST_DEV: begin
			d.pin_oe = 1'b1;
			d.clk_int = 1'b0;
		end
		ST_LINKED: begin
			d.pin_oe = q.pin_own && q.pin_low;
		end
		ST_BOOTED: begin
			d.clk_int = 1'b0;
			d.pin_oe = q.pin_own && q.pin_low;
		end
		default: begin
			d.st = ST_SETTLE;
			d.settle = '0;
		end
		endcase

		// rom boot runs its peripherals from the internal oscillator
		if (d.st != ST_BOOTED && d.st != ST_DEV) begin
			d.clk_int = 1'b1;
		end
		d.usb_en = (d.st == ST_SERIAL) && ext_osc_present;

		// resample overrides the machine; the pin is released meanwhile
		if (resample && q.st != ST_SETTLE) begin
			d.st = ST_SETTLE;
			d.settle = '0;
			d.pin_oe = 1'b0;
			d.usb_en = 1'b0;
			d.flash_start = 1'b0;
		end

		// sticky status: a new event wins over a clear in the same cycle
		d.irq_stat = (q.irq_stat & ~w1c) | ev;
		d.irq = |(d.irq_stat & d.irq_mask);

		// waitrequest drops for one cycle per request, read data with it
		d.waitreq = !((bus_req.read || bus_req.write) && q.waitreq);
		if (bus_req.read && q.waitreq) begin
			case (bus_req.address)
			`REG_CTRL: begin
				d.rdata = '0;
				d.rdata[`CTRL_PIN_OWN] = q.pin_own;
				d.rdata[`CTRL_PIN_LOW] = q.pin_low;
			end
			`REG_BOOT_RB: begin
				d.rdata = '0;
				d.rdata[`RB_PINS_LSB +: 4] = q.cap_pins;
				d.rdata[`RB_ALT_LSB +: 2] = q.cap_alt;
				d.rdata[`RB_SRC_LSB +: 4] = q.sel.src;
				d.rdata[`RB_SRC2_LSB +: 4] = q.sel.src2;
				d.rdata[`RB_STATE_LSB +: 4] = q.st;
				d.rdata[`RB_MCU_BIT] = q.sel.mcu_primary;
				d.rdata[`RB_DUAL_BIT] = q.sel.dual;
				d.rdata[`RB_CARD2_BIT] = q.sel.card_two;
			end
			`REG_IRQ_STAT: d.rdata = {28'h0, q.irq_stat};
			`REG_IRQ_MASK: d.rdata = {28'h0, q.irq_mask};
			`REG_LIVE_PINS: d.rdata = {28'h0, q.pins_s};
			default: d.rdata = '0;
			endcase
		end
	end

	// single state register, synchronous reset
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			q <= '0;
			q.st <= ST_SETTLE;
			q.cap_alt <= `ALT_DEFAULT;
			q.clk_int <= 1'b1;
			q.waitreq <= 1'b1;
			q.sel <= mk(SRC_NONE, 1'b0, SRC_NONE, 1'b0);
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state register
	assign bus_rsp.waitrequest = q.waitreq;
	assign bus_rsp.readdata = q.rdata;
	assign boot_sel = q.sel;
	assign flash_start = q.flash_start;
	assign clk_internal = q.clk_int;
	assign usb_dl_enable = q.usb_en;
	assign status_pin_out = q.pin_out;
	assign status_pin_oe = q.pin_oe;
	assign irq = q.irq;

endmodule
`default_nettype wire

/* File: src/boot_sel_params.svh */
// offsets, field positions, reset values and timing counts of the boot selector
`ifndef BOOT_SEL_PARAMS_SVH
`define BOOT_SEL_PARAMS_SVH

// register byte offsets
`define REG_CTRL       8'h00
`define REG_BOOT_RB    8'h04
`define REG_IRQ_STAT   8'h08
`define REG_IRQ_MASK   8'h0c
`define REG_LIVE_PINS  8'h10

// control register bits
`define CTRL_RESAMPLE  0
`define CTRL_PIN_OWN   1
`define CTRL_PIN_LOW   2

// readback register fields
`define RB_PINS_LSB    0
`define RB_ALT_LSB     4
`define RB_SRC_LSB     8
`define RB_SRC2_LSB    12
`define RB_STATE_LSB   16
`define RB_MCU_BIT     20
`define RB_DUAL_BIT    21
`define RB_CARD2_BIT   22

// interrupt bits
`define IRQ_W          4
`define IRQ_BOOTED     0
`define IRQ_FAIL       1
`define IRQ_LINK       2
`define IRQ_SAMPLED    3

// strap codes and defaults
`define ALT_DEFAULT    2'h0
`define STRAP_SER_LO   4'h0
`define STRAP_SER_HI   4'hf
`define STRAP_DEV_LO   4'h3
`define STRAP_DEV_HI   4'hc
`define N_SRC          9

// timing
`define MCLK_HZ        25000000
`define BLINK_HALF_MS  125
`define BLINK_HALF_CYC (`MCLK_HZ / 1000 * `BLINK_HALF_MS)
`define BLINK_CNT_W    24
`define SETTLE_CYC     2'h3

`endif

/* File: src/boot_sel_pkg.sv */
// types shared by the boot selector and its bench
package boot_sel_pkg;
	typedef enum logic [3:0] {
		SRC_NONE   = 4'h0,
		SRC_SERIAL = 4'h1,
		SRC_DEV    = 4'h2,
		SRC_SD     = 4'h3,
		SRC_EMMC   = 4'h4,
		SRC_SNOR   = 4'h5,
		SRC_SNAND  = 4'h6,
		SRC_SLC    = 4'h7,
		SRC_HBUS   = 4'h8
	} boot_src_e;

	typedef enum logic [3:0] {
		ST_SETTLE  = 4'h0,
		ST_RESOLVE = 4'h1,
		ST_FLASH   = 4'h2,
		ST_FAIL    = 4'h3,
		ST_SERIAL  = 4'h4,
		ST_LINKED  = 4'h5,
		ST_DEV     = 4'h6,
		ST_BOOTED  = 4'h7
	} boot_st_e;

	typedef struct packed {
		boot_src_e src;
		logic      mcu_primary;
		logic      dual;
		boot_src_e src2;
		logic      card_two;
	} map_entry_s;

	typedef struct packed {
		logic [1:0]  alt;
		logic        force_en;
		boot_src_e   force_src;
		logic [8:0]  forbid;
		logic        secure;
	} otp_cfg_s;

	typedef struct packed {
		logic done;
		logic empty;
		logic error;
	} flash_rsp_s;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [31:0] writedata;
	} avmm_req_s;

	typedef struct packed {
		logic        waitrequest;
		logic [31:0] readdata;
	} avmm_rsp_s;
endpackage

/* File: tb/boot_sel_assertions.sv */
// concurrent checks on the boot selector ports
`timescale 1ns/1ps
`default_nettype none
module boot_sel_checker
	import boot_sel_pkg::*;
#(
	parameter int unsigned BLINK_HALF_CYC = 8
) (
	input wire logic       mclk,
	input wire logic       sys_rst,
	input wire logic [3:0] boot_pins,
	input wire otp_cfg_s   otp_cfg,
	input wire flash_rsp_s flash_rsp,
	input wire logic       conn_usb,
	input wire logic       ext_osc_present,
	input wire avmm_req_s  bus_req,
	input wire avmm_rsp_s  bus_rsp,
	input wire map_entry_s boot_sel,
	input wire logic       flash_start,
	input wire logic       clk_internal,
	input wire logic       usb_dl_enable,
	input wire logic       status_pin_out,
	input wire logic       status_pin_oe
);
	int unsigned hold_q;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// cycles since the pin last moved in download; a stuck blink shows here
	always_ff @(posedge mclk) begin
		if (sys_rst || !usb_dl_enable || status_pin_oe != $past(status_pin_oe))
			hold_q <= 0;
		else
			hold_q <= hold_q + 1;
	end
	a_pin_open_drain: assert property (status_pin_oe |-> !status_pin_out)
		else $error("status pin driven high");
	a_dev_pin_low: assert property ($rose(boot_sel.src == SRC_DEV) |-> ##[0:2] status_pin_oe)
		else $error("dev boot left pin released");
	a_dev_straps: assert property ((boot_pins == 4'h3 || boot_pins == 4'hc) && boot_sel.src != SRC_NONE |-> boot_sel.src == SRC_DEV)
		else $error("dev strap not dev boot");
	a_serial_straps: assert property ((boot_pins == 4'h0 || boot_pins == 4'hf) && !otp_cfg.force_en && !otp_cfg.forbid[1] && boot_sel.src != SRC_NONE |-> boot_sel.src == SRC_SERIAL)
		else $error("serial strap not serial");
	a_flash_kind: assert property (flash_start |-> boot_sel.src inside {[SRC_SD:SRC_HBUS]} && clk_internal)
		else $error("flash probe bad source");
	a_usb_needs_osc: assert property (usb_dl_enable |-> $past(ext_osc_present))
		else $error("usb on without oscillator");
	a_secure_fail: assert property (flash_rsp.done && flash_rsp.error && otp_cfg.secure |-> ##[1:2] status_pin_oe)
		else $error("failure not shown on pin");
	a_boot_released: assert property (flash_rsp.done && !flash_rsp.error && !flash_rsp.empty |=> (!status_pin_oe)[*3])
		else $error("pin driven after boot");
	a_link_release: assert property (conn_usb && usb_dl_enable |-> ##2 (!status_pin_oe)[*4])
		else $error("blink kept after link");
	a_blink_hold: assert property (usb_dl_enable |-> hold_q <= BLINK_HALF_CYC + 1)
		else $error("blink stalled");
	a_bus_answer: assert property ((bus_req.read || bus_req.write) && bus_rsp.waitrequest |=> !bus_rsp.waitrequest ##1 bus_rsp.waitrequest)
		else $error("bus answer not one cycle");
	c_probe: cover property (flash_start);
	c_blink: cover property (usb_dl_enable && $rose(status_pin_oe));
	c_link: cover property (conn_usb && usb_dl_enable);
endmodule
bind boot_source_select_and_status boot_sel_checker #(
	.BLINK_HALF_CYC(BLINK_HALF_CYC)
) chk_i (.mclk, .sys_rst, .boot_pins, .otp_cfg, .flash_rsp, .conn_usb,
	.ext_osc_present, .bus_req, .bus_rsp, .boot_sel, .flash_start,
	.clk_internal, .usb_dl_enable, .status_pin_out, .status_pin_oe);
`default_nettype wire

/* File: tb/boot_far_side.sv */
// far side model: strap switches, boot flash and download host
`timescale 1ns/1ps
`default_nettype none
module boot_far_side
	import boot_sel_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic [3:0] strap_set,
	input  wire logic [1:0] mode,
	input  wire logic [2:0] lat,
	input  wire logic [1:0] link,
	input  wire logic       flash_start,
	output logic [3:0]      boot_pins,
	output flash_rsp_s      flash_rsp,
	output logic            conn_port_a,
	output logic            conn_port_b,
	output logic            conn_usb
);
	int cnt = -1;
	// straps move only under reset, since the device may sample them again
	always @(posedge mclk) begin
		if (sys_rst)
			boot_pins <= strap_set;
	end
	// flash answers a probe lat+1 cycles after flash_start; mode 1 empty, 2 error
	always @(posedge mclk) begin
		flash_rsp <= '0;
		if (sys_rst)
			cnt <= -1;
		else if (flash_start)
			cnt <= int'(lat);
		else if (cnt > 0)
			cnt <= cnt - 1;
		else if (cnt == 0) begin
			cnt <= -1;
			flash_rsp <= '{1'b1, mode == 2'd1, mode == 2'd2};
		end
	end
	// host link: 1 port a, 2 port b, 3 usb
	always @(posedge mclk) begin
		conn_port_a <= link == 2'd1;
		conn_port_b <= link == 2'd2;
		conn_usb <= link == 2'd3;
	end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the boot source selector
`timescale 1ns/1ps
`default_nettype none
module testbench
	import boot_sel_pkg::*;
;
	logic       mclk = 0, sys_rst = 1, standby_exit = 0, ext_osc_present = 1;
	logic [3:0] strap = 0, boot_pins, p;
	logic [1:0] mode = 0, link = 0;
	logic [2:0] lat = 1;
	logic [4:0] e;
	logic       dl;
	otp_cfg_s   otp_cfg = '0, o;
	avmm_req_s  bus_req = '0;
	avmm_rsp_s  bus_rsp;
	map_entry_s boot_sel;
	flash_rsp_s flash_rsp;
	logic       flash_start, clk_internal, usb_dl_enable, status_pin_out;
	logic       status_pin_oe, irq, conn_port_a, conn_port_b, conn_usb, po;
	logic [31:0] q, rs = 32'hf29e;
	int         bad_count = 0, check_count = 0, n;
	always #20 mclk = ~mclk;
	boot_source_select_and_status #(.BLINK_HALF_CYC(8)) dut (.mclk,
		.sys_rst, .boot_pins, .otp_cfg, .standby_exit, .flash_rsp,
		.conn_port_a, .conn_port_b, .conn_usb, .ext_osc_present, .bus_req,
		.bus_rsp, .boot_sel, .flash_start, .clk_internal, .usb_dl_enable,
		.status_pin_out, .status_pin_oe, .irq);
	boot_far_side far (.mclk, .sys_rst, .strap_set(strap), .mode, .lat,
		.link, .flash_start, .boot_pins, .flash_rsp, .conn_port_a,
		.conn_port_b, .conn_usb);
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	// expected {mcu primary, source} for default field; the mcu-primary
	// entries 9, 10, 13 and 14 also carry a second flash configuration
	function automatic logic [4:0] emap(input logic [3:0] v);
		case (v)
			4'h3, 4'hc: return {1'b0, SRC_DEV};
			4'h1: return {1'b0, SRC_SD};
			4'h2: return {1'b0, SRC_EMMC};
			4'h4: return {1'b0, SRC_SNOR};
			4'h5: return {1'b0, SRC_SNAND};
			4'h6: return {1'b0, SRC_SLC};
			4'h7: return {1'b1, SRC_SD};
			4'h8: return {1'b1, SRC_EMMC};
			4'hb: return {1'b1, SRC_SNOR};
			4'h9: return {1'b1, SRC_SNAND};
			4'ha: return {1'b1, SRC_SLC};
			4'hd: return {1'b1, SRC_EMMC};
			4'he: return {1'b1, SRC_SD};
			default: return {1'b0, SRC_SERIAL};
		endcase
	endfunction
	function automatic logic [3:0] est(input logic [3:0] s);
		return s == SRC_SERIAL ? ST_SERIAL : s == SRC_DEV ? ST_DEV : ST_BOOTED;
	endfunction
	task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] s);
		check_count++;
		if (x !== s) begin
			bad_count++;
			$display("CHECK FAILED %s exp %h got %h", nm, x, s);
		end
	endtask
	// one access; held until waitrequest is seen low, then one idle edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		bus_req <= '{!w, w, a, d};
		@(posedge mclk);
		while (bus_rsp.waitrequest !== 1'b0)
			@(posedge mclk);
		q = bus_rsp.readdata;
		bus_req <= '0;
		@(posedge mclk);
	endtask
	task automatic run(input logic [3:0] v, input otp_cfg_s c, input logic [1:0] m, input logic [3:0] es);
		mode <= m;
		otp_cfg <= c;
		strap <= v;
		sys_rst <= 1;
		repeat (8) @(posedge mclk);
		sys_rst <= 0;
		repeat (40) @(posedge mclk);
		bus(0, 8'h04, 0);
		cmp("state", es, q[19:16]);
		cmp("pins", v, q[3:0]);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// cuts a hang short
	initial begin
		#800000;
		bad_count++;
		final_report;
	end
	initial begin
		for (int i = 0; i < 22; i++) begin
			rs = xs(rs);
			p = i < 16 ? i[3:0] : rs[3:0];
			lat <= rs[6:4];
			e = emap(p);
			run(p, '0, 2'd0, est(e[3:0]));
			cmp("src", e[3:0], q[11:8]);
			cmp("mcu", e[4], q[20]);
			dl = p inside {4'h9, 4'ha, 4'hd, 4'he};
			cmp("dual", dl, q[21]);
			cmp("src2", dl ? SRC_SNOR : SRC_NONE, q[15:12]);
			cmp("sel", e[3:0], boot_sel.src);
			cmp("clk", e[3:0] == SRC_SERIAL, clk_internal);
			if (e[3:0] != SRC_SERIAL)
				cmp("oe", e[3:0] == SRC_DEV, status_pin_oe);
		end
		run(4'h1, '0, 2'd1, ST_SERIAL);
		run(4'h1, '0, 2'd2, ST_SERIAL);
		o = '0;
		o.secure = 1;
		run(4'h1, o, 2'd2, ST_FAIL);
		cmp("oe", 1, status_pin_oe);
		o = '0;
		o.force_en = 1;
		o.force_src = SRC_SNOR;
		run(4'h1, o, 2'd0, ST_BOOTED);
		cmp("src", SRC_SNOR, q[11:8]);
		run(4'hc, o, 2'd0, ST_DEV);
		o = '0;
		o.forbid[3] = 1;
		run(4'h1, o, 2'd0, ST_SERIAL);
		o = '0;
		o.alt = 2'h2;
		run(4'h3, o, 2'd0, ST_DEV);
		cmp("alt", 2'h2, q[5:4]);
		// field 1 has holes that fall back to serial, and a hyperbus cell
		o.alt = 2'h1;
		run(4'h5, o, 2'd0, ST_SERIAL);
		cmp("src", SRC_SERIAL, q[11:8]);
		run(4'h7, o, 2'd0, ST_BOOTED);
		cmp("src", SRC_HBUS, q[11:8]);
		// with serial download forbidden a failure has nowhere to go
		o = '0;
		o.forbid[1] = 1;
		run(4'h0, o, 2'd0, ST_FAIL);
		cmp("oe", 1, status_pin_oe);
		// each download link, usb only with the oscillator present
		for (int k = 1; k < 4; k++) begin
			ext_osc_present <= k[0];
			run(k == 2 ? 4'hf : 4'h0, '0, 2'd0, ST_SERIAL);
			cmp("usb", k[0], usb_dl_enable);
			n = 0;
			po = status_pin_oe;
			repeat (40) begin
				@(posedge mclk);
				n += int'(status_pin_oe !== po);
				po = status_pin_oe;
			end
			cmp("blink", 1, n >= 4);
			link <= k[1:0];
			repeat (6) @(posedge mclk);
			cmp("oe", 0, status_pin_oe);
			bus(0, 8'h04, 0);
			cmp("state", ST_LINKED, q[19:16]);
			link <= 2'd0;
		end
		ext_osc_present <= 1;
		run(4'h2, '0, 2'd0, ST_BOOTED);
		bus(0, 8'h08, 0);
		cmp("stat", 32'h9, q);
		cmp("irq", 0, irq);
		bus(1, 8'h0c, 32'hf);
		cmp("irq", 1, irq);
		bus(1, 8'h08, 32'hf);
		cmp("irq", 0, irq);
		standby_exit <= 1;
		@(posedge mclk);
		standby_exit <= 0;
		repeat (40) @(posedge mclk);
		bus(0, 8'h08, 0);
		cmp("stat", 32'h9, q);
		bus(1, 8'h00, 32'h1);
		repeat (40) @(posedge mclk);
		bus(0, 8'h00, 0);
		cmp("ctrl", 0, q);
		bus(1, 8'h04, 0);
		bus(0, 8'h04, 0);
		cmp("state", ST_BOOTED, q[19:16]);
		cmp("pins", 4'h2, q[3:0]);
		bus(0, 8'h10, 0);
		cmp("live", 4'h2, q);
		bus(0, 8'h20, 0);
		cmp("hole", 0, q);
		// software takes the pin after boot; oe follows one edge later
		bus(1, 8'h00, 32'h6);
		@(posedge mclk);
		cmp("own", 1, status_pin_oe);
		bus(0, 8'h00, 0);
		cmp("ctrl", 32'h6, q);
		final_report;
	end
endmodule
`default_nettype wire
